// ### core/ebs_lane_ctrl.sv
// external bus sizing, lane enable and halfword beat sequencing
`timescale 1ns/10ps
`include "ebs_defs.svh"
module ebs_lane_ctrl
    import ebs_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    // width strap
    input wire logic width_select_in,
    // core request
    input wire logic req_valid_in,
    input wire ebs_size_t req_size_in,
    input wire logic [1:0] req_addr_in,
    input wire logic req_write_in,
    input wire logic [31:0] req_wdata_in,
    output logic req_ready_out,
    output logic word_taken_out,
    output logic rd_valid_out,
    output logic [31:0] rd_data_out,
    output logic wide_mode_out,
    output logic [2:0] bus_state_out,
    // external bus pins
    output logic lane0_enable_n_out,
    output logic lane1_enable_n_out,
    output logic lane2_or_upper_strobe_pin_out,
    output logic lane3_or_half_addr_pin_out,
    input wire logic [31:0] data_in,
    output logic [31:0] data_out,
    output logic [31:0] data_oe_out
);
    ebs_state_t state_r, state_nxt;
    ebs_size_t size_r, size_nxt;
    logic [2:0] beat_r, beat_nxt;
    logic [1:0] addr_r, addr_nxt;
    logic write_r, write_nxt;
    logic wide_r;
    logic [31:0] wbuf_r, wbuf_nxt;
    logic accept, load_next, hi_nxt, drive_nxt;
    logic [3:0] pins_nxt;
    logic [31:0] dout_nxt, doe_nxt;
    logic [2:0] burst_last;

    // ------------------------------------------------------------
    // width strap
    // ------------------------------------------------------------
    // caught on every edge while reset is low, so the level seen
    // at the last reset edge is the one kept
    // R1 R5 strap sampled in reset
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            wide_r <= !width_select_in;
        end
        // R16 width held after release
    end

    // ------------------------------------------------------------
    // request capture
    // ------------------------------------------------------------
    assign accept = (state_r == EBS_ST_IDLE) && req_valid_in;
    assign burst_last = wide_r ? `EBS_BURST_LAST_W32 : `EBS_BURST_LAST_W16;

    always_comb begin
        size_nxt = accept ? req_size_in : size_r;
        write_nxt = accept ? req_write_in : write_r;
        addr_nxt = addr_r;
        if (accept) begin
            // misaligned low bits are masked by size
            case (req_size_in)
                EBS_SZ_BYTE: addr_nxt = req_addr_in;
                EBS_SZ_HALF: addr_nxt = {req_addr_in[1], 1'b0};
                default: addr_nxt = 2'b00;
            endcase
        end
    end

    // ------------------------------------------------------------
    // bus state sequence
    // ------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        beat_nxt = beat_r;
        case (state_r)
            EBS_ST_IDLE: begin
                if (req_valid_in) begin
                    state_nxt = EBS_ST_ADDR;
                end
            end
            EBS_ST_ADDR: begin
                beat_nxt = 3'h0;
                case (size_r)
                    // R9 two state single access
                    EBS_SZ_BYTE, EBS_SZ_HALF: state_nxt = EBS_ST_STRB;
                    // R12 R13 narrow word uses waits
                    EBS_SZ_WORD: state_nxt = wide_r ? EBS_ST_STRB : EBS_ST_WAIT1;
                    default: state_nxt = EBS_ST_BURST;
                endcase
            end
            EBS_ST_STRB: state_nxt = EBS_ST_IDLE;
            EBS_ST_WAIT1: state_nxt = EBS_ST_WAIT2;
            EBS_ST_WAIT2: state_nxt = EBS_ST_IDLE;
            EBS_ST_BURST: begin
                // R4 R15 burst beat count
                if (beat_r == burst_last) begin
                    state_nxt = EBS_ST_IDLE;
                end else begin
                    beat_nxt = beat_r + 3'h1;
                end
            end
            default: state_nxt = EBS_ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            state_r <= EBS_ST_IDLE;
            beat_r <= 3'h0;
            size_r <= EBS_SZ_BYTE;
            addr_r <= 2'b00;
            write_r <= 1'b0;
        end else if (ce_in) begin
            state_r <= state_nxt;
            beat_r <= beat_nxt;
            size_r <= size_nxt;
            addr_r <= addr_nxt;
            write_r <= write_nxt;
        end
    end

    // ------------------------------------------------------------
    // write buffer
    // ------------------------------------------------------------
    // a burst pulls a fresh word each time a new word's first beat starts
    assign load_next = write_r && (state_r == EBS_ST_BURST) && (state_nxt == EBS_ST_BURST)
                       && (wide_r || !beat_nxt[0]);
    assign wbuf_nxt = (accept || load_next) ? req_wdata_in : wbuf_r;

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            wbuf_r <= 32'h0000_0000;
            word_taken_out <= 1'b0;
        end else if (ce_in) begin
            wbuf_r <= wbuf_nxt;
            word_taken_out <= (accept && req_write_in) || load_next;
        end
    end

    // ------------------------------------------------------------
    // lane pins and data drive
    // ------------------------------------------------------------
    always_comb begin
        case (state_nxt)
            EBS_ST_WAIT2: hi_nxt = 1'b1;
            EBS_ST_BURST: hi_nxt = beat_nxt[0];
            EBS_ST_ADDR, EBS_ST_STRB: begin
                hi_nxt = (size_nxt == EBS_SZ_BYTE || size_nxt == EBS_SZ_HALF) && addr_nxt[1];
            end
            default: hi_nxt = 1'b0;
        endcase
    end

    // R13 low half from address state on
    assign drive_nxt = write_nxt && (state_nxt != EBS_ST_IDLE);

    // pins_nxt bit order: 3 dual addr pin, 2 dual strobe pin, 1, 0 lanes
    always_comb begin
        pins_nxt = `EBS_LANES_IDLE;
        if (state_nxt != EBS_ST_IDLE) begin
            if (wide_r) begin
                // R2 R3 wide lane encoding
                case (size_nxt)
                    EBS_SZ_BYTE: pins_nxt = ~(4'h1 << addr_nxt);
                    EBS_SZ_HALF: pins_nxt = addr_nxt[1] ? `EBS_LANES_HALF_HI : `EBS_LANES_HALF_LO;
                    // R4 burst all lanes low
                    default: pins_nxt = `EBS_LANES_WORD;
                endcase
            end else begin
                // R7 dual pins as strobe and A1
                case (size_nxt)
                    // R14 single access narrow encoding
                    EBS_SZ_BYTE: pins_nxt = {addr_nxt[1], 1'b1, !addr_nxt[0], addr_nxt[0]};
                    EBS_SZ_HALF: pins_nxt = {addr_nxt[1], 1'b1, 2'b00};
                    // R15 A1 toggles per beat
                    default: pins_nxt = {hi_nxt, 3'b000};
                endcase
            end
        end
    end

    ebs_data_mux ebs_data_mux_i (
        .wide_in(wide_r),
        .hi_half_in(hi_nxt),
        .drive_in(drive_nxt),
        .wbuf_in(wbuf_nxt),
        .dout_out(dout_nxt),
        .doe_out(doe_nxt)
    );

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            lane0_enable_n_out <= 1'b1;
            lane1_enable_n_out <= 1'b1;
            lane2_or_upper_strobe_pin_out <= 1'b1;
            lane3_or_half_addr_pin_out <= 1'b1;
            data_out <= 32'h0000_0000;
            data_oe_out <= 32'h0000_0000;
            req_ready_out <= 1'b0;
            bus_state_out <= EBS_ST_IDLE;
            wide_mode_out <= `EBS_WIDE_RESET;
        end else if (ce_in) begin
            lane0_enable_n_out <= pins_nxt[0];
            lane1_enable_n_out <= pins_nxt[1];
            lane2_or_upper_strobe_pin_out <= pins_nxt[2];
            lane3_or_half_addr_pin_out <= pins_nxt[3];
            data_out <= dout_nxt;
            data_oe_out <= doe_nxt;
            req_ready_out <= (state_nxt == EBS_ST_IDLE);
            bus_state_out <= state_nxt;
            wide_mode_out <= wide_r;
        end
    end

    // ------------------------------------------------------------
    // read capture
    // ------------------------------------------------------------
    // data is taken at the edge that closes each data state
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            rd_data_out <= 32'h0000_0000;
            rd_valid_out <= 1'b0;
        end else if (ce_in) begin
            rd_valid_out <= 1'b0;
            if (!write_r) begin
                case (state_r)
                    EBS_ST_STRB: begin
                        rd_valid_out <= 1'b1;
                        if (wide_r) begin
                            rd_data_out <= data_in;
                        end else if (addr_r[1]) begin
                            // R10 upper half read on low lines
                            rd_data_out <= {data_in[15:0], 16'h0000};
                        end else begin
                            // R11 lower half read
                            rd_data_out <= {16'h0000, data_in[15:0]};
                        end
                    end
                    // R12 low then high half
                    EBS_ST_WAIT1: rd_data_out[15:0] <= data_in[15:0];
                    EBS_ST_WAIT2: begin
                        rd_data_out[31:16] <= data_in[15:0];
                        rd_valid_out <= 1'b1;
                    end
                    EBS_ST_BURST: begin
                        if (wide_r) begin
                            rd_data_out <= data_in;
                            rd_valid_out <= 1'b1;
                        end else if (beat_r[0]) begin
                            rd_data_out[31:16] <= data_in[15:0];
                            rd_valid_out <= 1'b1;
                        end else begin
                            rd_data_out[15:0] <= data_in[15:0];
                        end
                    end
                    default: rd_valid_out <= 1'b0;
                endcase
            end
        end
    end
endmodule

// ### pkg/ebs_defs.svh
// constants of the external bus sizing and lane enable block
// What this block does
// R1: With the width strap inactive at reset the data bus runs 32 bits wide.
// R2: In 32-bit mode all four lane enables are driven, the dual pins acting as lanes two and three.
// R3: In 32-bit mode byte, halfword and word accesses lower the lanes set by size and offset.
// R4: A 32-bit burst lowers all lanes and runs an address state then four burst beats.
// R5: With the width strap active at reset the data bus runs 16 bits wide on lines 15:0.
// R6: In 16-bit mode data lines 31:16 are never driven.
// R7: In 16-bit mode the dual pins become the upper-byte strobe and halfword address bit 1.
// R8: The outside system changes the width strap only while reset is held.
// R9: In 16-bit mode byte and halfword accesses take an address state and a strobe state.
// R10: In 16-bit mode upper halfword data travels on lines 15:0 in both directions.
// R11: In 16-bit mode lower halfword data travels on lines 15:0 in both directions.
// R12: A 16-bit word read samples the low half in the first wait state and the high in the second.
// R13: A 16-bit word write drives the low half in address and first wait, the high half in second.
// R14: In 16-bit mode byte and halfword accesses drive A1 from the address and keep the strobe high.
// R15: In 16-bit word and burst transfers strobe and lanes stay low, A1 toggles, bursts run 8 beats.
// R16: The sampled width is held from reset release until the next reset.
`ifndef EBS_DEFS_SVH
`define EBS_DEFS_SVH

`define EBS_BURST_LAST_W32 3'h3
`define EBS_BURST_LAST_W16 3'h7
`define EBS_LANES_IDLE 4'hf
`define EBS_LANES_WORD 4'h0
`define EBS_LANES_HALF_LO 4'hc
`define EBS_LANES_HALF_HI 4'h3
`define EBS_WIDE_RESET 1'b1

`endif

// ### pkg/ebs_pkg.sv
// types of the external bus sizing and lane enable block
package ebs_pkg;

    typedef enum logic [1:0] {
        EBS_SZ_BYTE = 2'b00,
        EBS_SZ_HALF = 2'b01,
        EBS_SZ_WORD = 2'b10,
        EBS_SZ_BURST = 2'b11
    } ebs_size_t;

    typedef enum logic [2:0] {
        EBS_ST_IDLE = 3'b000,
        EBS_ST_ADDR = 3'b001,
        EBS_ST_STRB = 3'b010,
        EBS_ST_WAIT1 = 3'b011,
        EBS_ST_WAIT2 = 3'b100,
        EBS_ST_BURST = 3'b101
    } ebs_state_t;

endpackage

// ### core/ebs_data_mux.sv
// write data steering onto the external data lines
`timescale 1ns/10ps
module ebs_data_mux (
    // mode and beat
    input wire logic wide_in,
    input wire logic hi_half_in,
    input wire logic drive_in,
    // data
    input wire logic [31:0] wbuf_in,
    output logic [31:0] dout_out,
    output logic [31:0] doe_out
);
    genvar g;

    // upper half of the buffer folds down onto the low lines
    // R10 R11 halfword on low lines
    assign dout_out[15:0] = (!wide_in && hi_half_in) ? wbuf_in[31:16] : wbuf_in[15:0];
    assign dout_out[31:16] = wide_in ? wbuf_in[31:16] : 16'h0000;

    generate
        for (g = 0; g < 4; g = g + 1) begin : g_lane
            if (g < 2) begin : g_low
                assign doe_out[g*8 +: 8] = {8{drive_in}};
            end else begin : g_high
                // R6 upper lines floated
                assign doe_out[g*8 +: 8] = {8{drive_in & wide_in}};
            end
        end
    endgenerate
endmodule

// ### bench/ebs_mem_model.sv
// far-side memory model answering the read states
`timescale 1ns/10ps
module ebs_mem_model (
    // bus view
    input wire logic clk_in,
    input wire logic wide_in,
    input wire logic [2:0] state_in,
    input wire logic a1_in,
    input wire logic [31:0] word_in,
    // read data toward the bus
    output logic [31:0] data_out
);
    logic [31:0] last_r = 32'h0;
    // narrow bus: half chosen by the half address pin
    always_comb begin
        if (state_in < 3'h2 || state_in > 3'h5) begin
            data_out = ~last_r;
        end else if (wide_in) begin
            data_out = word_in;
        end else begin
            data_out = {~word_in[31:16], a1_in ? word_in[31:16] : word_in[15:0]};
        end
    end
    // released lines keep moving, so a stale sample never matches
    always_ff @(posedge clk_in) begin
        last_r <= data_out;
    end
endmodule

// ### bench/ebs_lane_ctrl_chk.sv
// port checker for the lane enable block
`timescale 1ns/10ps
module ebs_lane_ctrl_chk
    import ebs_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    input wire logic req_valid_in,
    input wire ebs_size_t req_size_in,
    input wire logic [1:0] req_addr_in,
    input wire logic req_ready_out,
    input wire logic wide_mode_out,
    input wire logic [2:0] bus_state_out,
    input wire logic lane0_enable_n_out,
    input wire logic lane1_enable_n_out,
    input wire logic lane2_or_upper_strobe_pin_out,
    input wire logic lane3_or_half_addr_pin_out,
    input wire logic [31:0] data_oe_out
);
    logic acc;
    logic [3:0] pins;
    assign acc = req_valid_in && req_ready_out && ce_in && bus_state_out == 3'h0;
    assign pins = {lane3_or_half_addr_pin_out, lane2_or_upper_strobe_pin_out,
        lane1_enable_n_out, lane0_enable_n_out};
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    property p_idle; wide_mode_out && bus_state_out == 3'h0 |-> pins == 4'hf; endproperty
    a_idle: assert property (p_idle) else $error("lane active in idle");
    property p_wbyte; acc && wide_mode_out && req_size_in == EBS_SZ_BYTE
        |=> pins == ~(4'h1 << $past(req_addr_in)) ##1 $stable(pins); endproperty
    a_wbyte: assert property (p_wbyte) else $error("byte lane wrong");
    property p_wburst; acc && wide_mode_out && req_size_in == EBS_SZ_BURST
        |=> (pins == 4'h0) [*5] ##1 bus_state_out == 3'h0; endproperty
    a_wburst: assert property (p_wburst) else $error("wide burst wrong");
    property p_hiz; !wide_mode_out |-> data_oe_out[31:16] == 16'h0; endproperty
    a_hiz: assert property (p_hiz) else $error("upper lines driven");
    property p_nsingle; acc && !wide_mode_out
        && (req_size_in == EBS_SZ_BYTE || req_size_in == EBS_SZ_HALF) |=> bus_state_out == 3'h1
        && pins[3:2] == {$past(req_addr_in[1]), 1'h1} ##1 bus_state_out == 3'h2
        ##1 bus_state_out == 3'h0; endproperty
    a_nsingle: assert property (p_nsingle) else $error("narrow single wrong");
    property p_nword; acc && !wide_mode_out && req_size_in == EBS_SZ_WORD
        |=> pins == 4'h0 ##1 pins == 4'h0 ##1 pins == 4'h8 ##1 bus_state_out == 3'h0;
    endproperty
    a_nword: assert property (p_nword) else $error("narrow word wrong");
    property p_nburst; acc && !wide_mode_out && req_size_in == EBS_SZ_BURST
        |=> pins == 4'h0 ##1 pins == 4'h0 ##1 pins == 4'h8 ##1 pins == 4'h0 ##1 pins == 4'h8
        ##1 pins == 4'h0 ##1 pins == 4'h8 ##1 pins == 4'h0 ##1 pins == 4'h8
        ##1 bus_state_out == 3'h0; endproperty
    a_nburst: assert property (p_nburst) else $error("narrow burst wrong");
    property p_hold; $past(rst_n_in) && $past(rst_n_in, 2) && $past(rst_n_in, 3)
        |-> $stable(wide_mode_out); endproperty
    a_hold: assert property (p_hold) else $error("width changed");
    c_wburst: cover property (acc && wide_mode_out && req_size_in == EBS_SZ_BURST);
    c_nword: cover property (acc && !wide_mode_out && req_size_in == EBS_SZ_WORD);
    c_nburst: cover property (acc && !wide_mode_out && req_size_in == EBS_SZ_BURST);
endmodule

bind ebs_lane_ctrl ebs_lane_ctrl_chk ebs_lane_ctrl_chk_i (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in), .req_valid_in(req_valid_in),
    .req_size_in(req_size_in), .req_addr_in(req_addr_in), .req_ready_out(req_ready_out),
    .wide_mode_out(wide_mode_out), .bus_state_out(bus_state_out),
    .lane0_enable_n_out(lane0_enable_n_out), .lane1_enable_n_out(lane1_enable_n_out),
    .lane2_or_upper_strobe_pin_out(lane2_or_upper_strobe_pin_out),
    .lane3_or_half_addr_pin_out(lane3_or_half_addr_pin_out), .data_oe_out(data_oe_out)
);

// ### bench/external_bus_sizing_lane_enables_test.sv
// self-checking bench for the bus sizing and lane enable block
`timescale 1ns/10ps
module external_bus_sizing_lane_enables_test;
    import ebs_pkg::*;
    logic clk = 1'h0, rst_n = 1'h0, ws = 1'h0, valid = 1'h0, wr = 1'h0, ce = 1'h1;
    ebs_size_t sz = EBS_SZ_BYTE;
    logic [1:0] ad = 2'h0;
    logic [31:0] wd = 32'h0, mw = 32'h5a3c96e1, bus, dout, doe, md, rdd;
    logic rdy, rdv, wide, l0, l1, p2, p3, rv [12];
    logic wt, tk [12];
    logic [2:0] st;
    logic [3:0] pin [12];
    logic [31:0] ob [12], oe [12], rb [12];
    int n_fail = 0, tests_run = 0;

    always #12.5 clk = ~clk;
    assign bus = (dout & doe) | (md & ~doe);

    ebs_lane_ctrl ebs_lane_ctrl_i (
        .clk_in(clk), .rst_n_in(rst_n), .ce_in(ce), .width_select_in(ws),
        .req_valid_in(valid), .req_size_in(sz), .req_addr_in(ad), .req_write_in(wr),
        .req_wdata_in(wd), .req_ready_out(rdy), .word_taken_out(wt), .rd_valid_out(rdv),
        .rd_data_out(rdd), .wide_mode_out(wide), .bus_state_out(st),
        .lane0_enable_n_out(l0), .lane1_enable_n_out(l1),
        .lane2_or_upper_strobe_pin_out(p2), .lane3_or_half_addr_pin_out(p3),
        .data_in(bus), .data_out(dout), .data_oe_out(doe)
    );
    ebs_mem_model ebs_mem_model_i (
        .clk_in(clk), .wide_in(wide), .state_in(st), .a1_in(p3), .word_in(mw), .data_out(md)
    );

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic complete_run;
        if (n_fail == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic do_reset(input logic w);
        rst_n = 1'h0;
        ws = w;
        repeat (12) @(negedge clk);
        rst_n = 1'h1;
        repeat (3) @(negedge clk);
    endtask

    // one transfer, pins logged once per clock for 12 clocks from the address state on
    task automatic go(input ebs_size_t s, input logic [1:0] a, input logic w,
        input logic [31:0] d);
        int i;
        sz = s;
        ad = a;
        wr = w;
        wd = d;
        valid = 1'h1;
        for (i = 0; i < 20 && st == 3'h0; i++) @(negedge clk);
        valid = 1'h0;
        if (st == 3'h0) begin
            n_fail++;
            complete_run;
        end
        for (i = 0; i < 12; i++) begin
            pin[i] = {p3, p2, l1, l0};
            ob[i] = dout;
            oe[i] = doe;
            rv[i] = rdv;
            tk[i] = wt;
            rb[i] = rdd;
            @(negedge clk);
        end
    endtask

    task automatic t_wide;
        ebs_size_t s [7] = '{EBS_SZ_BYTE, EBS_SZ_BYTE, EBS_SZ_BYTE, EBS_SZ_BYTE,
            EBS_SZ_HALF, EBS_SZ_HALF, EBS_SZ_WORD};
        logic [1:0] a [7] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0, 2'h2, 2'h0};
        logic [3:0] e [7] = '{4'he, 4'hd, 4'hb, 4'h7, 4'hc, 4'h3, 4'h0};
        do_reset(1'h0);
        chk(wide, 1'h1);
        for (int k = 0; k < 7; k++) begin
            mw = mw + 32'h01030507;
            go(s[k], a[k], 1'h0, 32'h0);
            chk(pin[0], e[k]);
            chk(pin[1], e[k]);
            chk(rv[2], 1'h1);
            chk(rb[2], mw);
        end
    endtask

    task automatic t_wburst;
        int n = 0;
        go(EBS_SZ_BURST, 2'h0, 1'h0, 32'h0);
        for (int k = 0; k < 12; k++) begin
            n += rv[k];
            chk(pin[k], k < 5 ? 4'h0 : 4'hf);
        end
        chk(n, 32'h4);
        chk(rb[11], mw);
    endtask

    task automatic t_narrow;
        logic [3:0] e [6] = '{4'h6, 4'h5, 4'he, 4'hd, 4'h4, 4'hc};
        logic [1:0] a [6] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0, 2'h2};
        logic [31:0] d = 32'hc3a51e78;
        do_reset(1'h1);
        chk(wide, 1'h0);
        // strap moved outside reset on purpose, it must be ignored
        ws = 1'h0;
        @(negedge clk);
        chk(wide, 1'h0);
        for (int k = 0; k < 6; k++) begin
            go(k < 4 ? EBS_SZ_BYTE : EBS_SZ_HALF, a[k], 1'h1, d);
            chk(pin[0], e[k]);
            chk(pin[1], e[k]);
            chk(oe[0], 32'h0000ffff);
            chk(tk[0], 1'h1);
            chk(ob[1][15:0], a[k][1] ? d[31:16] : d[15:0]);
        end
        mw = 32'h9e7d4b21;
        go(EBS_SZ_HALF, 2'h2, 1'h0, 32'h0);
        chk(rb[2], {mw[31:16], 16'h0});
        go(EBS_SZ_HALF, 2'h0, 1'h0, 32'h0);
        chk(rb[2], {16'h0, mw[15:0]});
    endtask

    task automatic t_nword;
        logic [31:0] d = 32'h7b2e81d4;
        go(EBS_SZ_WORD, 2'h0, 1'h1, d);
        for (int k = 0; k < 3; k++) begin
            chk(pin[k], k == 2 ? 4'h8 : 4'h0);
            chk(ob[k][15:0], k == 2 ? d[31:16] : d[15:0]);
        end
        mw = 32'h3c69a50f;
        go(EBS_SZ_WORD, 2'h0, 1'h0, 32'h0);
        chk(rv[3], 1'h1);
        chk(rb[3], mw);
    endtask

    task automatic t_nburst;
        int n = 0;
        int m = 0;
        logic [31:0] d = 32'h6d1f02b9;
        go(EBS_SZ_BURST, 2'h0, 1'h0, 32'h0);
        for (int k = 0; k < 12; k++) begin
            n += rv[k];
            if (k < 9) chk(pin[k], {k != 0 && k % 2 == 0, 3'h0});
        end
        chk(n, 32'h4);
        chk(rb[11], mw);
        // write burst: one word per two beats, low half first
        go(EBS_SZ_BURST, 2'h0, 1'h1, d);
        for (int k = 0; k < 12; k++) begin
            m += tk[k];
            if (k < 9) chk(ob[k][15:0], k != 0 && k % 2 == 0 ? d[31:16] : d[15:0]);
        end
        chk(oe[1], 32'h0000ffff);
        chk(m, 32'h4);
    endtask

    // clock enable low freezes the bus, even with a request up
    task automatic t_freeze;
        ce = 1'h0;
        sz = EBS_SZ_BYTE;
        wr = 1'h0;
        valid = 1'h1;
        repeat (4) @(negedge clk);
        chk(st, 3'h0);
        chk(wide, 1'h0);
        ce = 1'h1;
        go(EBS_SZ_BYTE, 2'h1, 1'h0, 32'h0);
        chk(pin[0], 4'h5);
    endtask

    initial begin
        t_wide;
        t_wburst;
        t_narrow;
        t_nword;
        t_nburst;
        t_freeze;
        complete_run;
    end
endmodule
